// file: src/eeld_pkg.sv
// package: register map, field layout and code constants of the ecc error log block
package eeld_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADDR_DIAG_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_ERROR_LOG = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  // ****************************************
  // diag control fields
  // ****************************************
  localparam int DC_FORCE_BIT = 9;
  localparam int DC_BYPASS_BIT = 8;
  localparam int DC_SUBST_LSB = 0;
  localparam int CHECK_W = 8;
  // ****************************************
  // error log fields
  // ****************************************
  localparam int EL_INHIBIT_BIT = 30;
  localparam int EL_HIGH_RATE_BIT = 29;
  localparam int EL_LOG_REQ_BIT = 28;
  localparam int EL_ADDR_LSB = 8;
  localparam int EL_ADDR_W = 20;
  localparam int EL_SYND_LSB = 0;
  // error address layout, relative to field lsb (bit 8)
  localparam int EA_LW_SEL = 0;
  localparam int EA_CHIP_LSB = 1;
  localparam int EA_CHIP_W_4K = 12;
  localparam int EA_CHIP_W_16K = 14;
  localparam int EA_BANK_4K = 13;
  localparam int EA_BANK_16K = 15;
  localparam int EA_BOARD_LSB = 16;
  localparam int EA_BOARD_W = 4;
  // ****************************************
  // substitute check bit address qualifier
  // ****************************************
  localparam int SUBST_ADDR_BIT_A = 3;
  localparam int SUBST_ADDR_BIT_B = 12;
  // ****************************************
  // interrupt status bits
  // ****************************************
  localparam int IRQ_W = 3;
  localparam int IRQ_LOGGED = 0;
  localparam int IRQ_HIGH_RATE = 1;
  localparam int IRQ_UNCORR = 2;
  // ****************************************
  // reset values and code
  // ****************************************
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [2:0] COL_TOP = 3'h6;
  localparam int DATA_W = 32;
endpackage

// file: src/eeld_sticky.sv
// sticky flag bank: hardware sets, write one clears, set wins
`timescale 1ns/10ps
module eeld_sticky #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // set and clear
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // flags
  output logic [W-1:0] q
);
  import eeld_pkg::*;
  logic [W-1:0] q_next;

  always_comb begin
    q_next = (q & ~clr) | set;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= q_next;
    end
  end
endmodule

// file: src/eeld_ecc.sv
// ecc check, syndrome and single bit correction
`timescale 1ns/10ps
module eeld_ecc (
  // array word
  input wire logic [eeld_pkg::DATA_W-1:0] data_in,
  input wire logic [eeld_pkg::CHECK_W-1:0] check_in,
  // substitute check bits
  input wire logic [eeld_pkg::CHECK_W-1:0] subst,
  input wire logic use_subst,
  // result
  output logic [eeld_pkg::CHECK_W-1:0] syndrome,
  output logic [eeld_pkg::DATA_W-1:0] data_fixed,
  output logic err,
  output logic correctable
);
  import eeld_pkg::*;

  // check column of one data bit
  function automatic logic [CHECK_W-1:0] col(input int i);
    col = {COL_TOP, i[4:0]};
  endfunction

  // check bits of a data word
  function automatic logic [CHECK_W-1:0] gen_check(input logic [DATA_W-1:0] d);
    logic [CHECK_W-1:0] c;
    c = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (d[i]) begin
        c = c ^ col(i);
      end
    end
    gen_check = c;
  endfunction

  logic [CHECK_W-1:0] check_used;
  logic hit_data;
  logic hit_check;

  always_comb begin
    check_used = use_subst ? subst : check_in;
    syndrome = gen_check(data_in) ^ check_used;
    data_fixed = data_in;
    hit_data = 1'b0;
    for (int i = 0; i < DATA_W; i++) begin
      if (syndrome == col(i)) begin
        data_fixed[i] = ~data_in[i];
        hit_data = 1'b1;
      end
    end
    hit_check = ($countones(syndrome) == 1);
    err = (syndrome != '0);
    correctable = hit_data | hit_check;
  end
endmodule

// file: src/eeld_top.sv
// top: ecc diagnostic control, tag suppression and error log with apb registers
// Function
// - force control selects the eight substitute check bits for ecc computation
// - bypass control disables correction, array data goes out unchanged
// - during bypass no corrected or uncorrectable tags are sent
// - during bypass error detection and logging continue as normal
// - substitutes apply only where bus address bits 3 and 12 are set
// - inhibit control blocks every corrected data tag
// - second error before service sets high error rate flag, write one clears
// - error on a read sets error log request flag, write one clears
// - while log request flag is set, corrected tags are suppressed
// - first error address captured read-only, held until serviced
// - address layout: board 27:24, bank 21 or 23, chip 20:09 or 22:09, select 8
// - syndrome loaded on read error unless one is held, kept until serviced
// - while a syndrome is held, later syndromes dropped, only high rate flag set
`timescale 1ns/10ps
module eeld_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // array read word
  input wire logic rd_valid,
  input wire logic [31:0] rd_bus_addr,
  input wire logic [eeld_pkg::DATA_W-1:0] rd_data,
  input wire logic [eeld_pkg::CHECK_W-1:0] rd_check,
  // array location of the read
  input wire logic chip_16k,
  input wire logic [eeld_pkg::EA_BOARD_W-1:0] rd_board,
  input wire logic rd_bank,
  input wire logic [eeld_pkg::EA_CHIP_W_16K-1:0] rd_chip,
  input wire logic rd_lw_sel,
  // read response
  output logic rsp_valid,
  output logic [eeld_pkg::DATA_W-1:0] rsp_data,
  output logic corrected_data_tag,
  output logic uncorrectable_data_tag,
  // interrupt
  output logic irq
);
  import eeld_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic force_reg, force_next;
  logic bypass_reg, bypass_next;
  logic [CHECK_W-1:0] subst_reg, subst_next;
  logic inhibit_reg, inhibit_next;
  logic [EL_ADDR_W-1:0] err_addr_reg, err_addr_next;
  logic [CHECK_W-1:0] synd_reg, synd_next;
  logic [IRQ_W-1:0] mask_reg, mask_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic [DATA_W-1:0] rsp_data_reg, rsp_data_next;
  logic crd_reg, crd_next;
  logic rds_reg, rds_next;
  logic irq_reg, irq_next;

  // ****************************************
  // ecc path
  // ****************************************
  logic use_subst;
  logic [CHECK_W-1:0] syndrome;
  logic [DATA_W-1:0] data_fixed;
  logic ecc_err;
  logic ecc_corr;

  always_comb begin
    use_subst = force_reg & rd_bus_addr[SUBST_ADDR_BIT_A] & rd_bus_addr[SUBST_ADDR_BIT_B];
  end

  eeld_ecc u_ecc (
    .data_in(rd_data),
    .check_in(rd_check),
    .subst(subst_reg),
    .use_subst(use_subst),
    .syndrome(syndrome),
    .data_fixed(data_fixed),
    .err(ecc_err),
    .correctable(ecc_corr)
  );

  // ****************************************
  // sticky flags
  // ****************************************
  logic wr_acc;
  logic rd_acc;
  logic [1:0] flag_set, flag_clr, flag_q;
  logic [IRQ_W-1:0] irq_set, irq_clr, irq_q;
  logic log_req;
  logic high_rate;
  logic err_event;
  logic log_free;

  always_comb begin
    wr_acc = psel & penable & pready_reg & pwrite;
    rd_acc = psel & penable & ~pready_reg & ~pwrite;
    log_req = flag_q[0];
    high_rate = flag_q[1];
    err_event = rd_valid & ecc_err;
    flag_clr = '0;
    if (wr_acc && paddr == ADDR_ERROR_LOG) begin
      flag_clr[0] = pwdata[EL_LOG_REQ_BIT];
      flag_clr[1] = pwdata[EL_HIGH_RATE_BIT];
    end
    log_free = ~log_req | flag_clr[0];
    flag_set[0] = err_event;
    flag_set[1] = err_event & ~log_free;
    irq_clr = '0;
    if (wr_acc && paddr == ADDR_IRQ_STATUS) begin
      irq_clr = pwdata[IRQ_W-1:0];
    end
    irq_set = '0;
    irq_set[IRQ_LOGGED] = err_event & log_free;
    irq_set[IRQ_HIGH_RATE] = flag_set[1];
    irq_set[IRQ_UNCORR] = err_event & ~ecc_corr;
  end

  eeld_sticky #(.W(2)) u_flags (
    .mclk(mclk),
    .rst(rst),
    .set(flag_set),
    .clr(flag_clr),
    .q(flag_q)
  );

  eeld_sticky #(.W(IRQ_W)) u_irq (
    .mclk(mclk),
    .rst(rst),
    .set(irq_set),
    .clr(irq_clr),
    .q(irq_q)
  );

  // ****************************************
  // error address layout
  // ****************************************
  function automatic logic [EL_ADDR_W-1:0] pack_addr(input logic d16k, input logic [EA_BOARD_W-1:0] board,
      input logic bank, input logic [EA_CHIP_W_16K-1:0] chip, input logic lw);
    logic [EL_ADDR_W-1:0] a;
    a = '0;
    a[EA_LW_SEL] = lw;
    a[EA_BOARD_LSB +: EA_BOARD_W] = board;
    if (d16k) begin
      a[EA_CHIP_LSB +: EA_CHIP_W_16K] = chip;
      a[EA_BANK_16K] = bank;
    end else begin
      a[EA_CHIP_LSB +: EA_CHIP_W_4K] = chip[EA_CHIP_W_4K-1:0];
      a[EA_BANK_4K] = bank;
    end
    pack_addr = a;
  endfunction

  // ****************************************
  // register words
  // ****************************************
  logic [31:0] diag_word;
  logic [31:0] log_word;

  always_comb begin
    diag_word = RESET_WORD;
    diag_word[DC_FORCE_BIT] = force_reg;
    diag_word[DC_BYPASS_BIT] = bypass_reg;
    diag_word[DC_SUBST_LSB +: CHECK_W] = subst_reg;
    log_word = RESET_WORD;
    log_word[EL_INHIBIT_BIT] = inhibit_reg;
    log_word[EL_HIGH_RATE_BIT] = high_rate;
    log_word[EL_LOG_REQ_BIT] = log_req;
    log_word[EL_ADDR_LSB +: EL_ADDR_W] = err_addr_reg;
    log_word[EL_SYND_LSB +: CHECK_W] = synd_reg;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    force_next = force_reg;
    bypass_next = bypass_reg;
    subst_next = subst_reg;
    inhibit_next = inhibit_reg;
    mask_next = mask_reg;
    err_addr_next = err_addr_reg;
    synd_next = synd_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    pready_next = psel & penable & ~pready_reg;
    // apb access, answered one cycle into the access phase
    if (psel && penable && !pready_reg) begin
      prdata_next = RESET_WORD;
      case (paddr)
        ADDR_DIAG_CONTROL: prdata_next = diag_word;
        ADDR_ERROR_LOG: prdata_next = log_word;
        ADDR_IRQ_STATUS: prdata_next[IRQ_W-1:0] = irq_q;
        ADDR_IRQ_MASK: prdata_next[IRQ_W-1:0] = mask_reg;
        default: pslverr_next = 1'b1;
      endcase
      if (!rd_acc) begin
        prdata_next = prdata_reg;
      end
    end
    if (wr_acc) begin
      case (paddr)
        ADDR_DIAG_CONTROL: begin
          force_next = pwdata[DC_FORCE_BIT];
          bypass_next = pwdata[DC_BYPASS_BIT];
          subst_next = pwdata[DC_SUBST_LSB +: CHECK_W];
        end
        ADDR_ERROR_LOG: begin
          inhibit_next = pwdata[EL_INHIBIT_BIT];
        end
        ADDR_IRQ_MASK: begin
          mask_next = pwdata[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // first error capture, later ones only raise the high rate flag
    if (err_event && log_free) begin
      err_addr_next = pack_addr(chip_16k, rd_board, rd_bank, rd_chip, rd_lw_sel);
      synd_next = syndrome;
    end
    // read response and tags
    rsp_valid_next = rd_valid;
    rsp_data_next = rsp_data_reg;
    crd_next = 1'b0;
    rds_next = 1'b0;
    if (rd_valid) begin
      rsp_data_next = bypass_reg ? rd_data : data_fixed;
      if (!bypass_reg && ecc_err) begin
        crd_next = ecc_corr & ~inhibit_reg & ~log_req;
        rds_next = ~ecc_corr;
      end
    end
    irq_next = |(irq_q & mask_reg);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      force_reg <= 1'b0;
      bypass_reg <= 1'b0;
      subst_reg <= '0;
      inhibit_reg <= 1'b0;
      err_addr_reg <= '0;
      synd_reg <= '0;
      mask_reg <= '0;
      prdata_reg <= RESET_WORD;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= '0;
      crd_reg <= 1'b0;
      rds_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      force_reg <= force_next;
      bypass_reg <= bypass_next;
      subst_reg <= subst_next;
      inhibit_reg <= inhibit_next;
      err_addr_reg <= err_addr_next;
      synd_reg <= synd_next;
      mask_reg <= mask_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
      crd_reg <= crd_next;
      rds_reg <= rds_next;
      irq_reg <= irq_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_comb begin
    prdata = prdata_reg;
    pready = pready_reg;
    pslverr = pslverr_reg;
    rsp_valid = rsp_valid_reg;
    rsp_data = rsp_data_reg;
    corrected_data_tag = crd_reg;
    uncorrectable_data_tag = rds_reg;
    irq = irq_reg;
  end
endmodule

// file: verification/eeld_cmdr.sv
// bus commander model: presents array read words to the block
`timescale 1ns/10ps
module eeld_cmdr (
  // clock
  input wire logic mclk,
  // array read word
  output logic rd_valid,
  output logic [31:0] rd_bus_addr,
  output logic [31:0] rd_data,
  output logic [7:0] rd_check,
  output logic chip_16k,
  output logic [3:0] rd_board,
  output logic rd_bank,
  output logic [13:0] rd_chip,
  output logic rd_lw_sel
);
  initial begin
    rd_valid = 1'b0;
    rd_bus_addr = 32'h0;
    rd_data = 32'h0;
    rd_check = 8'h0;
    chip_16k = 1'b0;
    {rd_board, rd_bank, rd_chip, rd_lw_sel} = 20'h0;
  end
  // one word, location taken from the address; outside the pulse address, data, check and location lines flip
  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [7:0] c, input logic k);
    @(posedge mclk);
    rd_valid <= 1'b1;
    rd_bus_addr <= a;
    rd_data <= d;
    rd_check <= c;
    chip_16k <= k;
    {rd_board, rd_bank, rd_chip, rd_lw_sel} <= {a[27:24], a[20], a[19:6], a[2]};
    @(posedge mclk);
    rd_valid <= 1'b0;
    rd_bus_addr <= ~a;
    rd_data <= ~d;
    rd_check <= ~c;
    {rd_board, rd_bank, rd_chip, rd_lw_sel} <= ~{a[27:24], a[20], a[19:6], a[2]};
  endtask
endmodule

// file: verification/eeld_top_chk.sv
// checker for the port behaviour of eeld_top
`timescale 1ns/10ps
module eeld_top_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // read path
  input wire logic rd_valid,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_data,
  input wire logic corrected_data_tag,
  input wire logic uncorrectable_data_tag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  sequence s_tag;
    corrected_data_tag || uncorrectable_data_tag;
  endsequence
  property p_rsp; rd_valid |=> rsp_valid; endproperty
  a_rsp: assert property (p_rsp) else $error("read not answered");
  property p_norsp; !rd_valid |=> !rsp_valid; endproperty
  a_norsp: assert property (p_norsp) else $error("stray response");
  property p_tag; s_tag |-> rsp_valid && !(corrected_data_tag && uncorrectable_data_tag); endproperty
  a_tag: assert property (p_tag) else $error("tag outside response");
  property p_hold; !rsp_valid |-> $stable(rsp_data); endproperty
  a_hold: assert property (p_hold) else $error("response data moved");
  property p_wait; s_acc |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("apb wait state wrong");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_err; pslverr |-> pready && (pwrite || prdata == 32'h0); endproperty
  a_err: assert property (p_err) else $error("bad error answer");
  property p_rdy; pready |-> psel && penable; endproperty
  a_rdy: assert property (p_rdy) else $error("pready without access");
endmodule
bind eeld_top eeld_top_chk chk_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rd_valid(rd_valid), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .corrected_data_tag(corrected_data_tag), .uncorrectable_data_tag(uncorrectable_data_tag));

// file: verification/tb_ecc_error_log_diag.sv
// testbench for eeld_top
`timescale 1ns/10ps
module tb_ecc_error_log_diag;
  import eeld_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rsp_data, rdat, ba, rd_bus_addr, rd_data;
  logic pready, pslverr, rerr, rsp_valid, corrected_data_tag, uncorrectable_data_tag, irq;
  logic rd_valid, chip_16k, rd_bank, rd_lw_sel;
  logic [7:0] rd_check;
  logic [3:0] rd_board;
  logic [13:0] rd_chip;
  logic [19:0] ea0;
  int failures = 0, check_count = 0;
  localparam logic [31:0] D = 32'h1234_5678;
  always #2.5 mclk = ~mclk;
  eeld_cmdr cmdr_u (.mclk(mclk), .rd_valid(rd_valid), .rd_bus_addr(rd_bus_addr), .rd_data(rd_data),
    .rd_check(rd_check), .chip_16k(chip_16k), .rd_board(rd_board), .rd_bank(rd_bank), .rd_chip(rd_chip),
    .rd_lw_sel(rd_lw_sel));
  eeld_top dut_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rd_valid(rd_valid),
    .rd_bus_addr(rd_bus_addr), .rd_data(rd_data), .rd_check(rd_check), .chip_16k(chip_16k),
    .rd_board(rd_board), .rd_bank(rd_bank), .rd_chip(rd_chip), .rd_lw_sel(rd_lw_sel), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .corrected_data_tag(corrected_data_tag),
    .uncorrectable_data_tag(uncorrectable_data_tag), .irq(irq));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] cbits(input logic [31:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 32; i++) if (d[i]) c ^= 8'hC0 | 8'(i);
    return c;
  endfunction
  function automatic logic [19:0] eaddr(input logic [31:0] a, input logic k);
    return k ? {a[27:24], a[20], a[19:6], a[2]} : {a[27:24], 2'b00, a[20], a[17:6], a[2]};
  endfunction
  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      if (++n > 20) begin
        failures++;
        wrap_up();
      end
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("reg", e, rdat);
  endtask
  // one read word, response judged at the edge after it is taken
  task automatic rdw(input logic [31:0] a, input logic [31:0] d, input logic [7:0] c, input logic k,
      input logic [31:0] ed, input logic [1:0] et);
    cmdr_u.rd(a, d, c, k);
    @(posedge mclk);
    chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
    chk("rsp_data", ed, rsp_data);
    chk("tags", {30'h0, et}, {30'h0, corrected_data_tag, uncorrectable_data_tag});
  endtask
  task automatic clr();
    apb(1'b1, ADDR_ERROR_LOG, 32'h3000_0000);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h7);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_regs();
    for (int i = 0; i < 4; i++) rchk(8'(4 * i), 32'h0);
    apb(1'b1, ADDR_DIAG_CONTROL, 32'hFFFF_FFFF);
    rchk(ADDR_DIAG_CONTROL, 32'h0000_03FF);
    apb(1'b1, ADDR_ERROR_LOG, 32'hFFFF_FFFF);
    rchk(ADDR_ERROR_LOG, 32'h4000_0000);
    apb(1'b1, ADDR_ERROR_LOG, 32'h0);
    apb(1'b1, ADDR_DIAG_CONTROL, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 32'h1, {31'h0, rerr});
  endtask
  task automatic s_log();
    ba = 32'h0A1F_F7C4;
    ea0 = eaddr(ba, 1'b0);
    rdw(32'h0, D, cbits(D), 1'b0, D, 2'b00);
    rdw(ba, D ^ 32'h20, cbits(D), 1'b0, D, 2'b10);
    rchk(ADDR_ERROR_LOG, {4'h1, ea0, 8'hC5});
    rdw(32'h0500_0040, D ^ 32'h4, cbits(D), 1'b0, D, 2'b00);
    rchk(ADDR_ERROR_LOG, {4'h3, ea0, 8'hC5});
    apb(1'b1, ADDR_ERROR_LOG, 32'h1000_0000);
    rchk(ADDR_ERROR_LOG, {4'h2, ea0, 8'hC5});
    ba = 32'h03B5_A00C;
    rdw(ba, D ^ 32'h8000_0000, cbits(D), 1'b1, D, 2'b10);
    rchk(ADDR_ERROR_LOG, {4'h3, eaddr(ba, 1'b1), 8'hDF});
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge mclk);
    chk("irq", 32'h1, {31'h0, irq});
    clr();
    repeat (2) @(posedge mclk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
  endtask
  task automatic s_bypass();
    rdw(32'h0, D ^ 32'h9, cbits(D), 1'b0, D ^ 32'h9, 2'b01);
    rchk(ADDR_IRQ_STATUS, 32'h5);
    clr();
    apb(1'b1, ADDR_DIAG_CONTROL, 32'h100);
    rdw(32'h0, D ^ 32'h1, cbits(D), 1'b0, D ^ 32'h1, 2'b00);
    rdw(32'h0, D ^ 32'h9, cbits(D), 1'b0, D ^ 32'h9, 2'b00);
    rchk(ADDR_ERROR_LOG, {4'h3, 20'h0, 8'hC0});
    clr();
    apb(1'b1, ADDR_DIAG_CONTROL, 32'h200 | 32'(cbits(D) ^ 8'h1));
    rdw(32'h0000_0008, D, cbits(D), 1'b0, D, 2'b00);
    rdw(32'h0000_1008, D, cbits(D), 1'b0, D, 2'b10);
    rchk(ADDR_ERROR_LOG, {4'h1, eaddr(32'h0000_1008, 1'b0), 8'h01});
    clr();
    apb(1'b1, ADDR_DIAG_CONTROL, 32'h0);
    apb(1'b1, ADDR_ERROR_LOG, 32'h4000_0000);
    rdw(32'h0, D ^ 32'h10, cbits(D), 1'b0, D, 2'b00);
    clr();
  endtask
  // mid-run reset empties the log
  task automatic s_reset();
    rdw(32'h0A1F_F7C4, D ^ 32'h20, cbits(D), 1'b0, D, 2'b10);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rchk(ADDR_ERROR_LOG, 32'h0);
    rchk(ADDR_IRQ_STATUS, 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    s_regs();
    s_log();
    s_bypass();
    s_reset();
    wrap_up();
  end
endmodule
